// File: design/mag_ctrl_pkg.sv
// Package: constants, state enum and carrier structs for the sensor reset and correction control
`default_nettype none
package mag_ctrl_pkg;

  // Register addresses
  localparam logic [7:0] CTRL_ADDR = 8'h11;
  localparam logic [7:0] DATA_FIRST_ADDR = 8'h01;
  localparam logic [7:0] DATA_LAST_ADDR = 8'h06;

  // Bit positions in the control register
  localparam int AUTO_BIT = 7;
  localparam int RAW_BIT = 5;
  localparam int ONESHOT_BIT = 4;

  // Reset values
  localparam logic AUTO_RST_VAL = 1'b0;
  localparam logic RAW_RST_VAL = 1'b0;
  localparam logic [7:0] BYTE_RST_VAL = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SR_TIME_NS = 1000;
  localparam int SR_CYCLES = (SR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SR_CNT_LOAD = 8'(SR_CYCLES - 1);

  // Data layout
  localparam int AXES = 3;
  localparam int DATA_BYTES = 6;

  typedef enum logic [0:0] {SR_IDLE, SR_BUSY} sr_state_t;

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } axes_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : mag_ctrl_pkg
`default_nettype wire

// File: design/mag_data_store.sv
// Output data byte store with registered read data
`default_nettype none
module mag_data_store
  import mag_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Write side
  input wire logic wr_i,
  input wire axes_t wdata_i,
  // Read side
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  output logic [7:0] rdata_o
);

  typedef struct packed {
    logic [DATA_BYTES-1:0][7:0] bytes;
    logic [7:0] rdata;
  } store_state_t;

  store_state_t q;
  store_state_t d;

  always_comb
  begin
    d = q;
    if (wr_i)
    begin
      // Most significant byte sits at the lower address
      d.bytes = {wdata_i.z[7:0], wdata_i.z[15:8], wdata_i.y[7:0], wdata_i.y[15:8],
                 wdata_i.x[7:0], wdata_i.x[15:8]};
    end
    if (rd_i)
    begin
      if (addr_i >= DATA_FIRST_ADDR && addr_i <= DATA_LAST_ADDR)
      begin
        d.rdata = q.bytes[3'(addr_i - DATA_FIRST_ADDR)];
      end
      else
      begin
        d.rdata = BYTE_RST_VAL;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;

endmodule : mag_data_store
`default_nettype wire

// File: design/magnetometer_control_two.sv
// Sensor reset and correction control register with its reset cycle and data correction
// Operation
// RULE_01: Auto enable set runs a sensor reset before every acquisition; clear runs none.
// RULE_02: Auto enable is write-only; its bit always reads zero.
// RULE_03: Host should always write the auto enable explicitly when configuring.
// RULE_04: Normal mode subtracts user offsets from each axis before storing.
// RULE_05: Raw mode stores axis values without user offsets.
// RULE_06: Factory calibration always applies to stored data bytes 0x01 to 0x06.
// RULE_07: Writing one to the one-shot bit starts a reset cycle; reads one while active.
// RULE_08: One-shot bit returns to zero by itself when the cycle completes.
// RULE_09: After reset auto enable, raw select and one-shot bit are zero.
// RULE_10: Auto enable is bit 7, raw select bit 5, one-shot bit 4.
// RULE_11: Unused bits read zero; writes to them do nothing.
`default_nettype none
module magnetometer_control_two
  import mag_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port from the serial interface logic
  input wire reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Measurement sequencer
  input wire logic acq_req_i,
  output logic acq_go_o,
  output logic sensor_reset_o,
  // Measurement data path
  input wire logic meas_valid_i,
  input wire axes_t meas_i,
  input wire axes_t factory_cal_i,
  input wire axes_t user_offset_i
);

  typedef struct packed {
    logic auto_en;
    logic raw;
    sr_state_t st;
    logic [7:0] cnt;
    logic pend;
    logic need_rst;
    logic acq_go;
    logic sel_ctrl;
    logic [7:0] ctrl_rdata;
    logic store_wr;
    axes_t store;
  } ctrl_state_t;

  ctrl_state_t q;
  ctrl_state_t d;
  logic ctrl_wr;
  logic start_man;
  logic sr_done;
  logic [7:0] mem_rdata;
  axes_t corr;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode and reset cycle control

  assign ctrl_wr = reg_req_i.wr && reg_req_i.addr == CTRL_ADDR;
  assign sr_done = q.st == SR_BUSY && q.cnt == 8'h00;
  // A start that lands on the completing edge restarts the cycle, so the request is not lost
  assign start_man = ctrl_wr && reg_req_i.wdata[ONESHOT_BIT] && (q.st == SR_IDLE || sr_done); // [RULE_07]

  always_comb
  begin
    d = q;
    d.acq_go = 1'b0;
    d.store_wr = 1'b0;
    if (ctrl_wr)
    begin
      d.auto_en = reg_req_i.wdata[AUTO_BIT]; // [RULE_10]
      d.raw = reg_req_i.wdata[RAW_BIT]; // [RULE_10] [RULE_11]
    end
    if (acq_req_i)
    begin
      d.pend = 1'b1;
      d.need_rst = q.auto_en; // [RULE_01]
    end
    case (q.st)
      SR_IDLE:
      begin
        if (start_man)
        begin
          d.st = SR_BUSY;
          d.cnt = SR_CNT_LOAD;
        end
        else if (q.pend && q.need_rst)
        begin
          d.st = SR_BUSY; // [RULE_01]
          d.cnt = SR_CNT_LOAD;
          d.need_rst = acq_req_i ? q.auto_en : 1'b0;
        end
        else if (q.pend)
        begin
          d.acq_go = 1'b1;
          d.pend = acq_req_i;
        end
      end
      SR_BUSY:
      begin
        if (start_man)
        begin
          d.cnt = SR_CNT_LOAD;
        end
        else if (sr_done)
        begin
          d.st = SR_IDLE; // [RULE_08]
        end
        else
        begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default:
      begin
        d.st = SR_IDLE;
      end
    endcase
    if (reg_req_i.rd)
    begin
      d.sel_ctrl = reg_req_i.addr == CTRL_ADDR;
      // Auto enable and the unused positions always read as zero
      d.ctrl_rdata = 8'h00; // [RULE_02] [RULE_11]
      d.ctrl_rdata[RAW_BIT] = q.raw;
      d.ctrl_rdata[ONESHOT_BIT] = q.st == SR_BUSY; // [RULE_07]
    end
    if (meas_valid_i)
    begin
      d.store_wr = 1'b1;
      d.store = corr;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0; // [RULE_09]
      q.auto_en <= AUTO_RST_VAL;
      q.raw <= RAW_RST_VAL;
      q.st <= SR_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data correction per axis

  genvar gi;
  generate
    for (gi = 0; gi < AXES; gi++)
    begin : g_axis
      logic [15:0] off;
      // Offset is subtracted after calibration; wrap-around is left to the caller's range
      assign off = q.raw ? 16'h0000 : user_offset_i[gi*16 +: 16]; // [RULE_04] [RULE_05]
      assign corr[gi*16 +: 16] = meas_i[gi*16 +: 16] + factory_cal_i[gi*16 +: 16] - off; // [RULE_06]
    end
  endgenerate

  mag_data_store u_store (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(q.store_wr),
    .wdata_i(q.store),
    .rd_i(reg_req_i.rd),
    .addr_i(reg_req_i.addr),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_o = q.sel_ctrl ? q.ctrl_rdata : mem_rdata;
  assign acq_go_o = q.acq_go;
  assign sensor_reset_o = q.st == SR_BUSY;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic [8:0] busy_len_q;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      busy_len_q <= 9'h000;
    end
    else
    begin
      busy_len_q <= sensor_reset_o ? busy_len_q + 9'h001 : 9'h000;
    end
  end

  a_auto_reads_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_02]
    reg_req_i.rd && reg_req_i.addr == CTRL_ADDR |=> reg_rdata_o[AUTO_BIT] == 1'b0)
    else $error("auto enable bit read back nonzero");

  a_unused_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_11]
    reg_req_i.rd && reg_req_i.addr == CTRL_ADDR |=> reg_rdata_o[6] == 1'b0 && reg_rdata_o[3:0] == 4'h0)
    else $error("unused control bits read nonzero");

  a_raw_readback: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_10]
    ctrl_wr ##1 (reg_req_i.rd && reg_req_i.addr == CTRL_ADDR && !ctrl_wr)
    |=> reg_rdata_o[RAW_BIT] == $past(reg_req_i.wdata[RAW_BIT], 2))
    else $error("raw select did not read back");

  a_oneshot_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_07]
    start_man |=> sensor_reset_o)
    else $error("one-shot start did not begin a cycle");

  a_cycle_length: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_08]
    $fell(sensor_reset_o) |-> busy_len_q >= 9'(SR_CYCLES))
    else $error("reset cycle ended early");

  a_cycle_ends: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_08]
    busy_len_q == 9'(SR_CYCLES) && !$past(start_man) |-> !sensor_reset_o)
    else $error("reset cycle did not clear by itself");

  a_auto_first: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_01]
    acq_req_i && q.auto_en && q.st == SR_IDLE && !q.pend |-> ##2 sensor_reset_o)
    else $error("no sensor reset before acquisition");

  a_no_auto_go: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_01]
    acq_req_i && !q.auto_en && q.st == SR_IDLE && !q.pend |-> ##1 (start_man or (##1 acq_go_o)))
    else $error("acquisition without auto reset delayed");

  a_store_value: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_04] [RULE_05] [RULE_06]
    meas_valid_i |=> q.store.x == 16'($past(meas_i.x) + $past(factory_cal_i.x)
      - ($past(q.raw) ? 16'h0000 : $past(user_offset_i.x))))
    else $error("stored axis value not corrected as selected");

  a_reset_values: assert property (@(posedge clk_i) // [RULE_09]
    $fell(sys_rst_i) |-> !q.auto_en && !q.raw && !sensor_reset_o)
    else $error("control bits not zero after reset");

  c_manual_cycle: cover property (@(posedge clk_i) disable iff (sys_rst_i) $fell(sensor_reset_o));
  c_auto_acq: cover property (@(posedge clk_i) disable iff (sys_rst_i) acq_go_o && q.auto_en);
  c_raw_store: cover property (@(posedge clk_i) disable iff (sys_rst_i) q.store_wr && q.raw);
  c_restart: cover property (@(posedge clk_i) disable iff (sys_rst_i) start_man && sr_done);

endmodule : magnetometer_control_two
`default_nettype wire

// File: verif/tb.sv
// Self-checking testbench for the sensor reset and correction control register
`default_nettype none
module tb
  import mag_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic acq_req = 1'b0;
  logic acq_go;
  logic sr;
  logic meas_valid = 1'b0;
  axes_t meas = '0;
  axes_t cal = '0;
  axes_t offs = '0;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int cnt;
  int hi;
  logic [7:0] got;
  logic [7:0] d;

  ////////////////////////////////////////////////////////////////////////////////
  magnetometer_control_two u_magnetometer_control_two (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .reg_req_i(req),
    .reg_rdata_o(rdata),
    .acq_req_i(acq_req),
    .acq_go_o(acq_go),
    .sensor_reset_o(sr),
    .meas_valid_i(meas_valid),
    .meas_i(meas),
    .factory_cal_i(cal),
    .user_offset_i(offs)
  );

  always #2 clk_i = ~clk_i;

  // Ceiling well above the roughly one thousand cycles the tests need
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(negedge clk_i);
    req.wr = 1'b0;
  endtask : wr

  // Read data stands until the next read, so sampling a cycle late is safe
  task automatic rd(input logic [7:0] a);
    @(negedge clk_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_i);
    req.rd = 1'b0;
    @(negedge clk_i);
    got = rdata;
  endtask : rd

  task automatic acq(input int exp_go, input int exp_hi);
    @(negedge clk_i);
    acq_req = 1'b1;
    cnt = 0;
    hi = 0;
    @(negedge clk_i);
    acq_req = 1'b0;
    while (cnt < 400)
    begin
      if (sr === 1'b1) hi++;
      if (acq_go === 1'b1) break;
      cnt++;
      @(negedge clk_i);
    end
    check(16'(cnt), 16'(exp_go));
    check(16'(hi), 16'(exp_hi));
  endtask : acq

  function automatic logic [7:0] exp_byte(input logic [7:0] a, input logic raw);
    logic [15:0] v;
    int i;
    i = (int'(a) - 1) / 2;
    v = meas[16*i +: 16] + cal[16*i +: 16] - (raw ? 16'h0000 : offs[16*i +: 16]);
    return a[0] ? v[15:8] : v[7:0];
  endfunction : exp_byte

  task final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h8e07));
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    rd(CTRL_ADDR);
    check(16'(got), 16'h0000);
    rd(DATA_FIRST_ADDR);
    check(16'(got), 16'h0000);
    $display("test reset values done");
    // One-shot with every bit set: unused and write-only bits must not show
    wr(CTRL_ADDR, 8'hff);
    hi = 0;
    while (sr === 1'b1 && hi < 400)
    begin
      hi++;
      @(negedge clk_i);
    end
    check(16'(hi), 16'(SR_CYCLES));
    rd(CTRL_ADDR);
    check(16'(got), 16'h0020);
    wr(CTRL_ADDR, 8'h10);
    rd(CTRL_ADDR);
    check(16'(got), 16'h0010);
    for (cnt = 0; cnt < 400 && sr === 1'b1; cnt++) @(negedge clk_i);
    rd(CTRL_ADDR);
    check(16'(got), 16'h0000);
    $display("test one-shot done");
    // Host sets the auto enable explicitly both ways
    wr(CTRL_ADDR, 8'h00);
    acq(1, 0);
    wr(CTRL_ADDR, 8'h80);
    acq(SR_CYCLES + 2, SR_CYCLES);
    rd(CTRL_ADDR);
    check(16'(got), 16'h0000);
    $display("test auto reset done");
    // Random data in both correction modes, alternating so each is seen
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($urandom()) & 8'hef;
      d[5] = i[0];
      // Write then read back to back, so the readback right after a write is exercised
      @(negedge clk_i);
      req.wr = 1'b1;
      req.addr = CTRL_ADDR;
      req.wdata = d;
      @(negedge clk_i);
      req.wr = 1'b0;
      req.rd = 1'b1;
      @(negedge clk_i);
      req.rd = 1'b0;
      check(16'(rdata), {8'h00, 2'b00, d[5], 5'h00});
      meas = 48'({$urandom(), $urandom()});
      cal = 48'({$urandom(), $urandom()});
      offs = 48'({$urandom(), $urandom()});
      @(negedge clk_i);
      meas_valid = 1'b1;
      @(negedge clk_i);
      meas_valid = 1'b0;
      repeat (2) @(negedge clk_i);
      rd(CTRL_ADDR);
      check(16'(got), {8'h00, 2'b00, d[5], 5'h00});
      for (int a = 1; a <= 6; a++)
      begin
        rd(8'(a));
        check(16'(got), 16'(exp_byte(8'(a), d[5])));
      end
      rd(8'h00);
      check(16'(got), 16'h0000);
    end
    $display("test data correction done");
    final_report();
  end

endmodule : tb
`default_nettype wire
